// *** core/vfd_regs.svh ***
// Offsets, field positions, reset values and timing counts of the display block.
// Assumes a 32-bit Wishbone slave port with 12 byte-address bits.
`ifndef VFD_REGS_SVH
`define VFD_REGS_SVH

`define ADDR_W          12
`define MODE0_OFS       12'h000
`define MODE1_OFS       12'h004
`define MASK_OFS        12'h008
`define PORT_BASE       12'h010
`define RAM_BASE        12'h100

`define MODE0_TYPE_BIT  5
`define MODE0_FLAG_BIT  7
`define MODE1_CYC_BIT   0
`define MODE1_DIG_LSB   4

`define MODE0_RST       8'h00
`define MODE1_RST       8'h00
`define MASK_RST        8'h00
`define LATCH_RST       8'h00

`define CYCLE_SHORT     1024
`define CYCLE_LONG      2048

`define PIN_COUNT       53
`define PORT_PIN_FIRST  13
`define PORT_COUNT      5
`define RAM_DEPTH       80
`define RAM_STRIDE      16
`define SEG_BYTES       5
`define SEG_BITS        40

`endif

// *** core/vfd_pkg.sv ***
// Types shared by the display output block and its helpers.
// Assumes vfd_regs.svh is on the include path.
`include "vfd_regs.svh"
package vfd_pkg;

  typedef enum logic [1:0] {STOPPED, BLANK, DIGIT, KEYSCAN} phase_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    phase_t      phase;
    logic [4:0]  digitCount;
    logic [5:0]  segCount;
    logic [3:0]  digitIdx;
    logic        dataValid;
    logic        mode2;
  } pin_ctrl_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdData;
    logic [6:0]  mode0;
    logic [7:0]  mode1;
    logic [5:0]  mask;
    logic [39:0] latch;
    phase_t      phase;
    logic [11:0] cnt;
    logic [3:0]  digitIdx;
    logic [2:0]  fetchIdx;
    logic [39:0] segBuf;
    logic [52:0] pins;
    logic        keyFlag;
  } vfd_state_t;

endpackage

// *** core/disp_ram.sv ***
// Display data memory: one CPU read/write port, one DMA read port.
// Assumes the caller only writes in-range addresses.
`timescale 1ns/1ns
`include "vfd_regs.svh"
module disp_ram #(
  parameter int DEPTH = `RAM_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       cpuWrEn,
  input  wire logic [6:0] cpuAddr,
  input  wire logic [7:0] cpuWrData,
  output logic      [7:0] cpuRdData,
  input  wire logic [6:0] dmaAddr,
  output logic      [7:0] dmaRdData
);

  logic [7:0] mem [DEPTH];

  // Whole window is plain RAM to the CPU
  always_ff @(posedge clock) begin
    if (cpuWrEn) begin
      mem[cpuAddr] <= cpuWrData;
    end
  end

  assign cpuRdData = (cpuAddr < DEPTH) ? mem[cpuAddr] : 8'h00;
  // DMA port is independent of any CPU access
  assign dmaRdData = (dmaAddr < DEPTH) ? mem[dmaAddr] : 8'h00;

endmodule // disp_ram

// *** core/pin_mux.sv ***
// Per-pin selection between digit strobe, segment data and port latch.
// Assumes the controller supplies counts already truncated to the pin budget.
`timescale 1ns/1ns
`include "vfd_regs.svh"
module pin_mux (
  input  wire vfd_pkg::pin_ctrl_t    ctrl,
  input  wire logic [39:0]           segBuf,
  input  wire logic [39:0]           latch,
  output logic      [`PIN_COUNT-1:0] pinValue
);
  import vfd_pkg::*;

  function automatic logic pinFunc(input pin_ctrl_t c, input logic [5:0] pin,
                                   input logic portBit, input logic [39:0] seg);
    logic [5:0] digEnd;
    logic [5:0] segEnd;
    logic [5:0] segIdx;
    logic       dataBit;
    digEnd  = {1'b0, c.digitCount};
    segEnd  = digEnd + c.segCount;
    segIdx  = c.mode2 ? pin : pin - digEnd;
    dataBit = c.dataValid && (segIdx < 6'(`SEG_BITS)) && seg[segIdx];
    case (c.phase)
      STOPPED: pinFunc = portBit;
      BLANK:   pinFunc = (pin < segEnd) ? 1'b0 : portBit;
      KEYSCAN: pinFunc = portBit;
      DIGIT: begin
        if (pin < digEnd) begin
          pinFunc = c.mode2 ? dataBit : (c.dataValid && pin == {2'b00, c.digitIdx});
        end else if (pin < segEnd) begin
          pinFunc = dataBit;
        end else begin
          pinFunc = portBit;
        end
      end
      default: pinFunc = 1'b0;
    endcase
  endfunction

  // Pins from 0 upward: digits, then segments, then ports
  for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
    logic portBit;
    if (i >= `PORT_PIN_FIRST) begin : g_port
      assign portBit = latch[i-`PORT_PIN_FIRST];
    end else begin : g_fixed
      assign portBit = 1'b0;
    end
    assign pinValue[i] = pinFunc(ctrl, 6'(i), portBit, segBuf);
  end

endmodule // pin_mux

// *** core/vfd_output_assign_keyscan.sv ***
// Display pin assignment, display RAM fetch and key-scan slot with Wishbone registers.
// Assumes a classic Wishbone master on the same clock and synchronous active-high reset.
`timescale 1ns/1ns
`include "vfd_regs.svh"

module vfd_output_assign_keyscan #(
  parameter int unsigned CYCLE_SHORT = `CYCLE_SHORT,
  parameter int unsigned CYCLE_LONG  = `CYCLE_LONG
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire vfd_pkg::wb_req_t      wbReq,
  output logic                       wbAck,
  output logic      [31:0]           wbDatOut,
  output logic      [`PIN_COUNT-1:0] displayOutPin,
  output logic                       keyScanFlag
);
  import vfd_pkg::*;

  vfd_state_t            st_reg;
  vfd_state_t            st_next;
  logic                  access;
  logic                  stopped;
  logic                  slotEnd;
  logic [11:0]           cycLast;
  logic [4:0]            digitCount;
  logic [5:0]            segRoom;
  logic [5:0]            segCount;
  logic [6:0]            cpuRamAddr;
  logic [7:0]            cpuRamData;
  logic [6:0]            dmaRamAddr;
  logic [7:0]            dmaRamData;
  logic                  ramWr;
  pin_ctrl_t             pinCtrl;
  logic [`PIN_COUNT-1:0] pinValue;

  function automatic logic isRam(input logic [11:0] a);
    isRam = (a >= `RAM_BASE) && (a < `RAM_BASE + 4 * `RAM_DEPTH);
  endfunction

  function automatic logic [6:0] ramIndex(input logic [11:0] a);
    ramIndex = 7'((a - `RAM_BASE) >> 2);
  endfunction

  assign access  = wbReq.cyc && wbReq.stb && !st_reg.ack;
  assign stopped = st_reg.mode1[7:`MODE1_DIG_LSB] == 4'h0;
  assign cycLast = st_reg.mode1[`MODE1_CYC_BIT] ? 12'(CYCLE_LONG - 1)
                                                : 12'(CYCLE_SHORT - 1);
  assign slotEnd = st_reg.cnt == cycLast;

  // Field value 1..15 selects 2..16 digits
  assign digitCount = {1'b0, st_reg.mode1[7:`MODE1_DIG_LSB]} + 5'd1;
  assign segRoom    = 6'(`PIN_COUNT) - {1'b0, digitCount};
  assign segCount   = ({1'b0, st_reg.mode0[4:0]} > segRoom) ? segRoom
                                                            : {1'b0, st_reg.mode0[4:0]};

  // Digit k takes byte j of its data from index k + 16*j
  assign dmaRamAddr = 7'(st_reg.digitIdx + `RAM_STRIDE * st_reg.fetchIdx);
  assign cpuRamAddr = ramIndex(wbReq.adr);
  assign ramWr      = access && wbReq.we && wbReq.sel[0] && isRam(wbReq.adr);

  assign pinCtrl.phase      = st_reg.phase;
  assign pinCtrl.digitCount = digitCount;
  assign pinCtrl.segCount   = segCount;
  assign pinCtrl.digitIdx   = st_reg.digitIdx;
  assign pinCtrl.dataValid  = st_reg.fetchIdx == 3'(`SEG_BYTES);
  assign pinCtrl.mode2      = st_reg.mode0[`MODE0_TYPE_BIT];

  disp_ram #(
    .DEPTH(`RAM_DEPTH)
  ) u_ram (
    .clock     (clock),
    .cpuWrEn   (ramWr),
    .cpuAddr   (cpuRamAddr),
    .cpuWrData (wbReq.dat[7:0]),
    .cpuRdData (cpuRamData),
    .dmaAddr   (dmaRamAddr),
    .dmaRdData (dmaRamData)
  );

  pin_mux u_mux (
    .ctrl     (pinCtrl),
    .segBuf   (st_reg.segBuf),
    .latch    (st_reg.latch),
    .pinValue (pinValue)
  );

  always_comb begin
    st_next     = st_reg;
    st_next.ack = access;

    // Register reads
    if (access && !wbReq.we) begin
      st_next.rdData = 32'h0000_0000;
      if (wbReq.adr == `MODE0_OFS) begin
        st_next.rdData[7:0] = {st_reg.keyFlag, st_reg.mode0};
      end else if (wbReq.adr == `MODE1_OFS) begin
        st_next.rdData[7:0] = st_reg.mode1;
      end else if (wbReq.adr == `MASK_OFS) begin
        st_next.rdData[7:0] = {2'b00, st_reg.mask};
      end else if (isRam(wbReq.adr)) begin
        st_next.rdData[7:0] = cpuRamData;
      end
      for (int p = 0; p < `PORT_COUNT; p++) begin
        if (wbReq.adr == 12'(`PORT_BASE + 4 * p)) begin
          st_next.rdData[7:0] = st_reg.latch[8*p +: 8];
        end
      end
    end

    // Register writes; the flag bit is never stored
    if (access && wbReq.we && wbReq.sel[0]) begin
      if (wbReq.adr == `MODE0_OFS) begin
        st_next.mode0 = wbReq.dat[6:0];
      end else if (wbReq.adr == `MODE1_OFS) begin
        st_next.mode1 = wbReq.dat[7:0];
      end else if (wbReq.adr == `MASK_OFS) begin
        st_next.mask = wbReq.dat[5:0];
      end
      for (int p = 0; p < `PORT_COUNT; p++) begin
        if (wbReq.adr == 12'(`PORT_BASE + 4 * p)) begin
          st_next.latch[8*p +: 8] = wbReq.dat[7:0];
        end
      end
    end

    // Display sequencing
    if (stopped) begin
      st_next.phase    = STOPPED;
      st_next.cnt      = 12'h000;
      st_next.digitIdx = 4'h0;
      st_next.fetchIdx = 3'h0;
    end else begin
      st_next.cnt = slotEnd ? 12'h000 : st_reg.cnt + 12'h001;
      case (st_reg.phase)
        STOPPED: begin
          st_next.phase = BLANK;
          st_next.cnt   = 12'h000;
        end
        BLANK, KEYSCAN: begin
          if (slotEnd) begin
            st_next.phase    = DIGIT;
            st_next.digitIdx = 4'h0;
            st_next.fetchIdx = 3'h0;
          end
        end
        DIGIT: begin
          if (st_reg.fetchIdx < 3'(`SEG_BYTES)) begin
            st_next.segBuf[8*st_reg.fetchIdx +: 8] = dmaRamData;
            st_next.fetchIdx = st_reg.fetchIdx + 3'h1;
          end
          if (slotEnd) begin
            st_next.fetchIdx = 3'h0;
            if ({1'b0, st_reg.digitIdx} >= digitCount - 5'd1) begin
              st_next.phase = KEYSCAN;
            end else begin
              st_next.digitIdx = st_reg.digitIdx + 4'h1;
            end
          end
        end
        default: st_next.phase = STOPPED;
      endcase
    end

    // Flag and pins both follow the current phase one cycle later
    st_next.keyFlag = st_reg.phase == KEYSCAN;
    st_next.pins    = pinValue;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg       <= '0;
      st_reg.mode0 <= 7'(`MODE0_RST);
      st_reg.mode1 <= `MODE1_RST;
      st_reg.mask  <= 6'(`MASK_RST);
      st_reg.latch <= {`PORT_COUNT{`LATCH_RST}};
      st_reg.phase <= STOPPED;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wbAck         = st_reg.ack;
  assign wbDatOut      = st_reg.rdData;
  assign displayOutPin = st_reg.pins;
  assign keyScanFlag   = st_reg.keyFlag;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic [11:0] scanLen_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      scanLen_reg <= 12'h000;
    end else begin
      scanLen_reg <= keyScanFlag ? scanLen_reg + 12'h001 : 12'h000;
    end
  end

  sequence scanEnds;
    $fell(keyScanFlag) && !st_reg.mode0[`MODE0_TYPE_BIT] && !stopped;
  endsequence

  sequence stopHeld;
    $past(st_reg.phase) == STOPPED;
  endsequence

  chk_scan_blank: assert property (keyScanFlag |-> displayOutPin[12:0] == 13'h0000)
    else $error("display outputs not zero during key scan");

  chk_scan_latch: assert property (keyScanFlag |-> displayOutPin[52:13] == $past(st_reg.latch))
    else $error("port latches not driven during key scan");

  chk_scan_length: assert property ($fell(keyScanFlag) && $stable(st_reg.mode1) |->
      scanLen_reg == (st_reg.mode1[`MODE1_CYC_BIT] ? 12'(CYCLE_LONG) : 12'(CYCLE_SHORT)))
    else $error("key scan slot length differs from one display cycle");

  chk_first_digit: assert property (scanEnds |-> ##[1:8] displayOutPin[0])
    else $error("digit 0 not strobed after key scan");

  chk_one_strobe: assert property (!st_reg.mode0[`MODE0_TYPE_BIT] && !keyScanFlag |->
      $onehot0(displayOutPin[1:0]))
    else $error("more than one digit strobe active");

  chk_stop_release: assert property (stopHeld |->
      displayOutPin[12:0] == 13'h0000 && displayOutPin[52:13] == $past(st_reg.latch))
    else $error("stopped display pins not released to ports");

  chk_start_blank: assert property ($past(st_reg.phase) == BLANK |->
      displayOutPin[1:0] == 2'b00)
    else $error("output during first display cycle after start");

  chk_flag_read: assert property (wbAck && $past(wbReq.adr == `MODE0_OFS && !wbReq.we) |->
      wbDatOut[`MODE0_FLAG_BIT] == $past(keyScanFlag))
    else $error("key scan flag read back wrong");

  chk_pin_budget: assert property (6'({1'b0, digitCount}) + segCount <= 6'(`PIN_COUNT))
    else $error("digit plus segment pins exceed the pin count");

  chk_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack held for more than one cycle");

endmodule // vfd_output_assign_keyscan

// *** verification/vfd_panel_model.sv ***
// Display panel seen from its grid and anode lines.
// Assumes digit strobes sit on the lowest DIGITS pins.
`timescale 1ns/1ns
module vfd_panel_model #(
  parameter int DIGITS = 3
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [52:0] displayOutPin,
  input  wire logic        keyScanFlag,
  output logic      [7:0]  frameCount,
  output logic             strobeClash
);
  logic prevFirst;

  always_ff @(posedge clock) begin
    if (rst) begin
      prevFirst   <= 1'b0;
      frameCount  <= 8'h00;
      strobeClash <= 1'b0;
    end else begin
      prevFirst <= displayOutPin[0];
      // One frame per rise of the first grid
      if (displayOutPin[0] && !prevFirst) begin
        frameCount <= frameCount + 8'h01;
      end
      // Two grids at once, or a grid lit in key scan, disturbs the panel
      if ($countones(displayOutPin[DIGITS-1:0]) > 1 ||
          (keyScanFlag && |displayOutPin[DIGITS-1:0])) begin
        strobeClash <= 1'b1;
      end
    end
  end
endmodule // vfd_panel_model

// *** verification/test_vfd_output_assign_keyscan.sv ***
// Self-checking bench: Wishbone register calls and display pin checks.
// Assumes short slots of 16 and 32 clocks set through parameters.
`timescale 1ns/1ns
`include "vfd_regs.svh"
module test_vfd_output_assign_keyscan;
  import vfd_pkg::*;
  localparam int L = 16;
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  wb_req_t          wbReq = '0;
  logic             wbAck;
  logic [31:0]      wbDatOut;
  logic [52:0]      displayOutPin;
  logic             keyScanFlag;
  logic [7:0]       frameCount;
  logic             strobeClash;
  logic [39:0]      lat = 40'h12_3456_789a;
  int               n_fail = 0;
  int               n_compared = 0;
  int               cycles = 0;
  int               len;

  always #10 clock = ~clock;

  vfd_output_assign_keyscan #(.CYCLE_SHORT(16), .CYCLE_LONG(32)) DUT (
    .clock(clock), .rst(rst), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
    .displayOutPin(displayOutPin), .keyScanFlag(keyScanFlag));

  vfd_panel_model #(.DIGITS(3)) panel (
    .clock(clock), .rst(rst), .displayOutPin(displayOutPin),
    .keyScanFlag(keyScanFlag), .frameCount(frameCount), .strobeClash(strobeClash));

  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask

  // Classic cycle: hold until ack is sampled, release at that edge
  task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    wbReq.cyc <= 1'b1;
    wbReq.stb <= 1'b1;
    wbReq.we  <= we;
    wbReq.adr <= a;
    wbReq.sel <= 4'h1;
    wbReq.dat <= {24'h00_0000, d};
    @(posedge clock);
    while (wbAck !== 1'b1) @(posedge clock);
    q = wbDatOut;
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    check(q, exp, what);
  endtask

  task automatic ks_len(output int n);
    while (keyScanFlag !== 1'b1) @(posedge clock);
    n = 0;
    while (keyScanFlag === 1'b1) begin
      n++;
      @(posedge clock);
    end
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(displayOutPin, 0, "pins after reset");
    rdc(`MODE0_OFS, 0, "mode0 reset");
    rdc(`MODE1_OFS, 0, "mode1 reset");
    rdc(`MASK_OFS, 0, "mask reset");
    wr(`MASK_OFS, 8'hFF);
    rdc(`MASK_OFS, 32'h0000_003f, "mask width");
    rdc(12'h0FC, 0, "unmapped read");
    for (int p = 0; p < 5; p++) wr(`PORT_BASE + 12'(4 * p), lat[8*p +: 8]);
    wr(`RAM_BASE + 12'h13C, 8'hA5);
    rdc(`RAM_BASE + 12'h13C, 32'h0000_00a5, "spare ram");
    wr(`MODE0_OFS, 8'hFF);
    rdc(`MODE0_OFS, 32'h0000_007f, "flag ignores write");
    repeat (2) @(posedge clock);
    check(displayOutPin, {lat, 13'h0000}, "stopped pins");
    wr(`RAM_BASE, 8'h15);
    wr(`RAM_BASE + 12'h004, 8'h0A);
    wr(`RAM_BASE + 12'h008, 8'h00);
    wr(`MODE0_OFS, 8'h05);
    wr(`MODE1_OFS, 8'h24);
    repeat (4) @(posedge clock);
    check(displayOutPin[12:0], 0, "first cycle blank");
    while (keyScanFlag !== 1'b1) @(posedge clock);
    repeat (2) @(posedge clock);
    check(displayOutPin, {lat, 13'h0000}, "key scan pins");
    rdc(`MODE0_OFS, 32'h0000_0085, "flag set");
    // Scan line change during key scan
    wr(`PORT_BASE + 12'h00C, 8'h5A);
    lat[31:24] = 8'h5A;
    repeat (2) @(posedge clock);
    check(displayOutPin[44:37], 8'h5A, "scan line");
    while (keyScanFlag === 1'b1) @(posedge clock);
    repeat (8) @(posedge clock);
    check(displayOutPin[7:0], 8'b1010_1001, "digit 0");
    check(displayOutPin[52:13], lat, "free pins");
    repeat (L) @(posedge clock);
    check(displayOutPin[7:0], 8'b0101_0010, "digit 1");
    repeat (L) @(posedge clock);
    check(displayOutPin[7:0], 8'b0000_0100, "digit 2");
    ks_len(len);
    check(len, L, "short slot");
    check(frameCount, 2, "two frames");
    wr(`MODE1_OFS, 8'h25);
    ks_len(len);
    ks_len(len);
    check(len, 2 * L, "long slot");
    // Mode 2 puts data on the grid pins, so overlap is judged in mode 1 only
    check(strobeClash, 1'b0, "grid overlap");
    wr(`MODE0_OFS, 8'h25);
    while (keyScanFlag !== 1'b1) @(posedge clock);
    while (keyScanFlag === 1'b1) @(posedge clock);
    repeat (8) @(posedge clock);
    check(displayOutPin[7:0], 8'h15, "mode 2 digit 0");
    wr(`MODE1_OFS, 8'h00);
    repeat (3) @(posedge clock);
    check(displayOutPin, {lat, 13'h0000}, "stop releases");
    check(keyScanFlag, 1'b0, "flag clear");
    report_and_stop();
  end
endmodule // test_vfd_output_assign_keyscan
